/* File: design/bpgc_consts.svh */
// Purpose: Shared constants of the pattern generator and checker.
// Assumes: Included by its bare name from every design file that needs it.
// Notes: Timing figures are given in their own unit and converted where used.
`ifndef BPGC_CONSTS_SVH
`define BPGC_CONSTS_SVH

// System clock rate in hertz and the error report interval in seconds.
`define BPGC_CLK_HZ 20000000
`define BPGC_SEC_TIME_S 1
// Error counter width and the width of the port selector.
`define BPGC_CNT_W 32
`define BPGC_PORT_W 3
// Pseudo-random register length and its nonzero start value.
`define BPGC_SR_W 23
`define BPGC_PRBS_SEED 23'h7fffff
// Tap positions of the short and the long sequence.
`define BPGC_TAP15_A 14
`define BPGC_TAP15_B 13
`define BPGC_TAP23_A 22
`define BPGC_TAP23_B 17
// Sync detector: error-free run to lock, window length and error limit to drop lock.
`define BPGC_RUN_W 8
`define BPGC_LOCK_RUN 8'h20
`define BPGC_LOSS_WIN 8'h40
`define BPGC_LOSS_ERRS 8'h10

`endif

/* File: design/bpgc_pkg.sv */
// Purpose: Types of the pattern generator and checker.
// Assumes: Constants come from bpgc_consts.svh.
// Notes: Used only through scoped names.
`default_nettype none
package bpgc_pkg;

   // Selectable test sequences.
   typedef enum logic [1:0] {PAT_ZEROS, PAT_ONES, PAT_PRBS15, PAT_PRBS23} bpgc_pat_e;

   // Detector lock state.
   typedef enum logic {SYNC_HUNT, SYNC_LOCKED} bpgc_sync_e;

endpackage : bpgc_pkg

`default_nettype wire

/* File: design/bpgc_prbs_if.sv */
// Purpose: Control and result of one pseudo-random register.
// Assumes: One user and one register core per instance.
// Notes: The clock and reset travel as plain ports.
`timescale 1ns/1ps
`default_nettype none

interface bpgc_prbs_if;
   logic step;
   logic restart;
   logic seed_en;
   logic seed_bit;
   logic poly_long;
   logic fb_bit;

   modport core (input step, input restart, input seed_en, input seed_bit, input poly_long, output fb_bit);
   modport user (output step, output restart, output seed_en, output seed_bit, output poly_long, input fb_bit);
endinterface : bpgc_prbs_if

`default_nettype wire

/* File: design/bpgc_prbs.sv */
// Purpose: Shift register that produces either pseudo-random sequence.
// Assumes: step is a one-cycle strobe per bit.
// Notes: With seed_en set the register takes the given bit instead of its feedback.
`timescale 1ns/1ps
`default_nettype none
`include "bpgc_consts.svh"

module bpgc_prbs (
   input wire logic sys_clk_i,   // System clock.
   input wire logic sys_rst_i,   // Asynchronous reset, active high.
   bpgc_prbs_if.core p           // Register control and feedback bit.
);

   logic [`BPGC_SR_W-1:0] sr_reg;
   logic fb;
   logic in_bit;

   // Feedback of the selected polynomial, which is also the next sequence bit.
   assign fb = p.poly_long ? (sr_reg[`BPGC_TAP23_A] ^ sr_reg[`BPGC_TAP23_B])
                           : (sr_reg[`BPGC_TAP15_A] ^ sr_reg[`BPGC_TAP15_B]);
   assign in_bit = p.seed_en ? p.seed_bit : fb;
   assign p.fb_bit = fb;

   // The register restarts from a nonzero value so it never sticks at zero.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         sr_reg <= `BPGC_PRBS_SEED;
      else if (p.restart)
         sr_reg <= `BPGC_PRBS_SEED;
      else if (p.step)
         sr_reg <= {sr_reg[`BPGC_SR_W-2:0], in_bit};
   end

   // The register only moves on a bit strobe or a restart.
   chk_prbs_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (!p.step && !p.restart) |=> $stable(sr_reg))
      else $error("Pattern register moved without a bit strobe.");

endmodule : bpgc_prbs

`default_nettype wire

/* File: design/bpgc_top.sv */
// Purpose: Bit error rate test engine: pattern generator, sync detector and error counters.
// Assumes: Transmit and receive bit strobes and data come from line logic on sys_clk_i.
// Notes: Pattern and invert are taken when a test starts and hold for the whole test.
`timescale 1ns/1ps
`default_nettype none
`include "bpgc_consts.svh"

module bpgc_top #(
   parameter int unsigned SEC_CYCLES = `BPGC_SEC_TIME_S * `BPGC_CLK_HZ, // Cycles per one second.
   parameter int unsigned CNT_W = `BPGC_CNT_W,                          // Error counter width.
   parameter int unsigned PORT_W = `BPGC_PORT_W                         // Port selector width.
) (
   input wire logic sys_clk_i,                 // System clock, 20 MHz.
   input wire logic sys_rst_i,                 // Asynchronous reset, active high.
   input wire logic tx_bit_en_i,               // Transmit bit strobe.
   input wire logic host_data_i,               // Host bit to send outside a test.
   input wire logic rx_valid_i,                // Receive bit strobe.
   input wire logic rx_data_i,                 // Received line bit.
   input wire logic start_i,                   // Start a test, one-cycle pulse.
   input wire logic stop_i,                    // End the running test, one-cycle pulse.
   input wire logic [PORT_W-1:0] port_sel_i,   // Port for the test to start.
   input wire logic dir_sel_i,                 // Direction for the test to start.
   input wire bpgc_pkg::bpgc_pat_e pattern_i,  // Sequence for the test to start.
   input wire logic invert_i,                  // Invert setting for the test to start.
   input wire logic insert_err_i,              // Insert one error, pulse.
   input wire logic clear_i,                   // Clear error counts, pulse.
   input wire logic reset_all_i,               // Stop all tests and clear, pulse.
   output logic tx_data_o,                     // Outgoing line bit.
   output logic tx_valid_o,                    // Outgoing bit strobe.
   output logic active_o,                      // A test is running.
   output logic [PORT_W-1:0] port_o,           // Port of the latest test.
   output logic dir_o,                         // Direction of the latest test.
   output logic sync_o,                        // Detector locked.
   output logic [CNT_W-1:0] err_total_o,       // Errors since reset or clear.
   output logic [CNT_W-1:0] err_sec_o          // Errors in the last second.
);
   // Default clocking for the checks below.
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   localparam int unsigned SEC_W = $clog2(SEC_CYCLES + 1);
   bpgc_prbs_if gen_if();
   bpgc_prbs_if chk_if();
   logic active_reg, active_next;
   logic [PORT_W-1:0] port_reg;
   logic dir_reg;
   bpgc_pkg::bpgc_pat_e pat_reg;
   logic inv_reg;
   logic tx_data_reg, tx_valid_reg;
   logic ins_pend_reg, ins_pend_next;
   bpgc_pkg::bpgc_sync_e sync_reg, sync_next;
   logic locked_reg;
   logic [`BPGC_RUN_W-1:0] run_reg, run_next;
   logic [`BPGC_RUN_W-1:0] win_reg, win_next;
   logic [`BPGC_RUN_W-1:0] ecnt_reg, ecnt_next;
   logic [CNT_W-1:0] total_reg, sec_reg, acc_reg;
   logic [SEC_W-1:0] div_reg;
   logic tick_reg;
   // Pattern bit for a sequence, given the register feedback.
   function automatic logic pat_bit(input bpgc_pkg::bpgc_pat_e p, input logic fb);
      case (p)
         bpgc_pkg::PAT_ZEROS: pat_bit = 1'b0;
         bpgc_pkg::PAT_ONES: pat_bit = 1'b1;
         default: pat_bit = fb;
      endcase
   endfunction : pat_bit
   // Counter step that stops at the top instead of wrapping.
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic inc);
      sat_inc = (inc && (v != {CNT_W{1'b1}})) ? v + {{(CNT_W-1){1'b0}}, 1'b1} : v;
   endfunction : sat_inc
   // Command decode; a start is refused while a test runs.
   wire start_ok = start_i && !active_reg && !reset_all_i;
   wire clr = clear_i || reset_all_i;
   wire is_prbs = (pat_reg == bpgc_pkg::PAT_PRBS15) || (pat_reg == bpgc_pkg::PAT_PRBS23);
   wire tx_step = active_reg && tx_bit_en_i;
   wire rx_step = active_reg && rx_valid_i;
   wire locked = (sync_reg == bpgc_pkg::SYNC_LOCKED);
   // Test state: started once, ended by stop or reset-all.
   assign active_next = start_ok ? 1'b1 : ((stop_i || reset_all_i) ? 1'b0 : active_reg);
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         active_reg <= 1'b0;
         port_reg <= '0;
         dir_reg <= 1'b0;
         pat_reg <= bpgc_pkg::PAT_ZEROS;
         inv_reg <= 1'b0;
      end
      else
      begin
         active_reg <= active_next;
         if (start_ok)
         begin
            port_reg <= port_sel_i;
            dir_reg <= dir_sel_i;
            pat_reg <= pattern_i;
            inv_reg <= invert_i;
         end
      end
   end
   // Generator register hookup.
   assign gen_if.step = tx_step;
   assign gen_if.restart = start_ok;
   assign gen_if.seed_en = 1'b0;
   assign gen_if.seed_bit = 1'b0;
   assign gen_if.poly_long = (pat_reg == bpgc_pkg::PAT_PRBS23);
   bpgc_prbs u_gen (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .p(gen_if)
   );
   // Outgoing bit: pattern, optionally inverted, with one pending error folded in.
   wire tx_bit = pat_bit(pat_reg, gen_if.fb_bit) ^ inv_reg ^ ins_pend_reg;
   // A new request in the cycle its predecessor is used stays pending.
   assign ins_pend_next = (ins_pend_reg && !tx_step) || (insert_err_i && active_reg) ;
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         tx_data_reg <= 1'b0;
         tx_valid_reg <= 1'b0;
         ins_pend_reg <= 1'b0;
      end
      else
      begin
         tx_valid_reg <= tx_bit_en_i;
         ins_pend_reg <= ins_pend_next && active_next;
         if (tx_bit_en_i)
            tx_data_reg <= active_reg ? tx_bit : host_data_i;
      end
   end
   // Checker register: loads received bits while hunting, runs free once locked.
   wire rx_bit = rx_data_i ^ inv_reg;
   assign chk_if.step = rx_step;
   assign chk_if.restart = start_ok;
   assign chk_if.seed_en = !locked;
   assign chk_if.seed_bit = rx_bit;
   assign chk_if.poly_long = (pat_reg == bpgc_pkg::PAT_PRBS23);
   bpgc_prbs u_chk (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .p(chk_if)
   );
   // Each received bit against its expected bit; constant patterns need no seeding.
   wire exp_bit = pat_bit(pat_reg, chk_if.fb_bit);
   wire bit_err = rx_step && (rx_bit != exp_bit);
   wire bit_ok = rx_step && !bit_err;
   wire cnt_err = bit_err && locked;
   wire win_end = (win_reg == `BPGC_LOSS_WIN - 8'h01);
   // Lock hunt and loss of lock over a window of received bits.
   always_comb
   begin
      sync_next = sync_reg;
      run_next = run_reg;
      win_next = win_reg;
      ecnt_next = ecnt_reg;
      case (sync_reg)
         bpgc_pkg::SYNC_HUNT:
         begin
            win_next = '0;
            ecnt_next = '0;
            if (bit_err)
               run_next = '0;
            else if (bit_ok)
            begin
               run_next = run_reg + 8'h01;
               if (run_reg == `BPGC_LOCK_RUN - 8'h01)
               begin
                  sync_next = bpgc_pkg::SYNC_LOCKED;
                  run_next = '0;
               end
            end
         end
         bpgc_pkg::SYNC_LOCKED:
         begin
            if (rx_step)
            begin
               win_next = win_end ? '0 : win_reg + 8'h01;
               ecnt_next = win_end ? '0 : ecnt_reg + {7'h00, bit_err};
               if (bit_err && (ecnt_reg == `BPGC_LOSS_ERRS - 8'h01))
                  sync_next = bpgc_pkg::SYNC_HUNT;
            end
         end
         default: sync_next = bpgc_pkg::SYNC_HUNT;
      endcase
      if (!active_reg || start_ok)
         sync_next = bpgc_pkg::SYNC_HUNT;
   end
   // Detector state and its lock flag, which drives the sync output.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sync_reg <= bpgc_pkg::SYNC_HUNT;
         locked_reg <= 1'b0;
         run_reg <= '0;
         win_reg <= '0;
         ecnt_reg <= '0;
      end
      else
      begin
         sync_reg <= sync_next;
         locked_reg <= (sync_next == bpgc_pkg::SYNC_LOCKED);
         run_reg <= run_next;
         win_reg <= win_next;
         ecnt_reg <= ecnt_next;
      end
   end
   // One-second tick from the system clock.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_reg <= (div_reg == SEC_W'(SEC_CYCLES - 1));
         div_reg <= (div_reg == SEC_W'(SEC_CYCLES - 1)) ? '0 : div_reg + {{(SEC_W-1){1'b0}}, 1'b1};
      end
   end
   // Error counters; an error in the clearing cycle is kept as the first count.
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         total_reg <= '0;
         acc_reg <= '0;
         sec_reg <= '0;
      end
      else if (clr)
      begin
         total_reg <= {{(CNT_W-1){1'b0}}, cnt_err};
         acc_reg <= {{(CNT_W-1){1'b0}}, cnt_err};
         sec_reg <= '0;
      end
      else
      begin
         total_reg <= sat_inc(total_reg, cnt_err);
         if (tick_reg)
         begin
            sec_reg <= sat_inc(acc_reg, cnt_err);
            acc_reg <= '0;
         end
         else
            acc_reg <= sat_inc(acc_reg, cnt_err);
      end
   end
   // Outputs straight from flip-flops.
   assign tx_data_o = tx_data_reg;
   assign tx_valid_o = tx_valid_reg;
   assign active_o = active_reg;
   assign port_o = port_reg;
   assign dir_o = dir_reg;
   assign sync_o = locked_reg;
   assign err_total_o = total_reg;
   assign err_sec_o = sec_reg;
   // Checks on the behaviour above.
   chk_single_test: assert property (active_reg && start_i |=> $stable(port_reg) && $stable(dir_reg))
      else $error("A start during a running test changed the test.");
   chk_host_data: assert property (tx_bit_en_i && !active_reg |=> tx_data_o == $past(host_data_i))
      else $error("Host data not passed outside a test.");
   chk_const_pattern: assert property (tx_step && !is_prbs && !ins_pend_reg
      |=> tx_data_o == ($past(pat_reg == bpgc_pkg::PAT_ONES) ^ $past(inv_reg)))
      else $error("Constant pattern bit wrong.");
   chk_insert_once: assert property (ins_pend_reg && tx_step && !insert_err_i |=> !ins_pend_reg)
      else $error("Inserted error not consumed by one bit.");
   chk_clear_keeps: assert property (clear_i && !reset_all_i && !stop_i && active_reg
      |=> active_reg && err_total_o <= 1 && err_sec_o == 0)
      else $error("Clear did not zero counts or stopped the test.");
   chk_reset_all: assert property (reset_all_i |=> !active_o && err_sec_o == 0 && err_total_o <= 1)
      else $error("Reset-all left a test or a count.");
   chk_lock_run: assert property ($rose(locked_reg) |-> $past(run_reg) == `BPGC_LOCK_RUN - 8'h01)
      else $error("Lock declared before a full error-free run.");
   chk_count_locked: assert property (!locked && !clr |=> $stable(err_total_o))
      else $error("Errors counted while unlocked.");
   chk_sec_update: assert property (!tick_reg && !clr |=> $stable(err_sec_o))
      else $error("Per-second count changed off the second tick.");
   chk_sync_out: assert property (locked && bit_err && (ecnt_reg == `BPGC_LOSS_ERRS - 8'h01) |=> !sync_o)
      else $error("Sync output still high after too many errors.");
endmodule : bpgc_top
`default_nettype wire

/* File: verification/bpgc_far_end.sv */
// Purpose: Far-end model that returns every sent line bit to the receiver, like a remote loopback.
// Assumes: The bench asks for bit errors by loading a count of returned bits to corrupt.
// Notes: Between bits the returned data line toggles, so a stale value is never taken as a good bit.
`timescale 1ns/1ps
`default_nettype none

module bpgc_far_end (
   input wire logic sys_clk_i,        // System clock.
   input wire logic tx_valid_i,       // Sent bit strobe from the block.
   input wire logic tx_data_i,        // Sent bit from the block.
   input wire logic flip_ld_i,        // Load a new corruption count.
   input wire logic [7:0] flip_n_i,   // Number of returned bits to corrupt.
   output logic rx_valid_o,           // Returned bit strobe.
   output logic rx_data_o             // Returned bit.
);
   logic [7:0] flip_reg;

   // Start quiet with nothing to corrupt.
   initial
   begin
      rx_valid_o = 1'b0;
      rx_data_o = 1'b0;
      flip_reg = 8'h00;
   end

   // Each sent bit comes back one cycle later, corrupted while the count is not spent.
   always @(posedge sys_clk_i)
   begin
      rx_valid_o <= tx_valid_i;
      if (tx_valid_i)
         rx_data_o <= tx_data_i ^ (flip_reg != 8'h00);
      else
         rx_data_o <= ~rx_data_o;
      if (flip_ld_i)
         flip_reg <= flip_n_i;
      else if (tx_valid_i && flip_reg != 8'h00)
         flip_reg <= flip_reg - 8'h01;
   end
endmodule : bpgc_far_end

`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench of the test pattern engine, looped back through the far-end model.
// Assumes: One second is shortened to 100 cycles; bit strobes come every other cycle.
// Notes: Expected streams come from a reference shift register kept in the bench.
`timescale 1ns/1ps
`default_nettype none
`include "bpgc_consts.svh"

module tb;
   localparam int unsigned SEC = 100;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic tx_bit_en_i = 1'b0;
   logic host_data_i = 1'b0;
   logic start_i = 1'b0;
   logic stop_i = 1'b0;
   logic [2:0] port_sel_i = 3'h0;
   logic dir_sel_i = 1'b0;
   bpgc_pkg::bpgc_pat_e pattern_i = bpgc_pkg::PAT_ZEROS;
   logic invert_i = 1'b0;
   logic insert_err_i = 1'b0;
   logic clear_i = 1'b0;
   logic reset_all_i = 1'b0;
   logic flip_ld = 1'b0;
   logic [7:0] flip_n = 8'h00;
   logic tx_on = 1'b0;
   wire logic rx_valid_i;
   wire logic rx_data_i;
   logic tx_data_o, tx_valid_o, active_o, dir_o, sync_o;
   logic [2:0] port_o;
   logic [31:0] err_total_o, err_sec_o;
   int err_total = 0;
   int total_checks = 0;
   int d;

   bpgc_top #(.SEC_CYCLES(SEC)) bpgc_top_inst (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .tx_bit_en_i(tx_bit_en_i), .host_data_i(host_data_i),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .start_i(start_i), .stop_i(stop_i),
      .port_sel_i(port_sel_i), .dir_sel_i(dir_sel_i), .pattern_i(pattern_i), .invert_i(invert_i),
      .insert_err_i(insert_err_i), .clear_i(clear_i), .reset_all_i(reset_all_i), .tx_data_o(tx_data_o),
      .tx_valid_o(tx_valid_o), .active_o(active_o), .port_o(port_o), .dir_o(dir_o), .sync_o(sync_o),
      .err_total_o(err_total_o), .err_sec_o(err_sec_o));

   bpgc_far_end bpgc_far_end_inst (
      .sys_clk_i(sys_clk_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .flip_ld_i(flip_ld),
      .flip_n_i(flip_n), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));

   // The clock toggles every half period of 25 ns.
   always #25 sys_clk_i = ~sys_clk_i;

   // Bit strobes every other cycle; the host bit changes with each new strobe.
   always @(negedge sys_clk_i)
   begin
      tx_bit_en_i <= tx_on & ~tx_bit_en_i;
      if (tx_on && !tx_bit_en_i)
         host_data_i <= ~host_data_i;
   end

   // Prints the verdict and ends the run.
   task automatic give_verdict;
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // Compares a one-bit result.
   task automatic cmp_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_bit

   // Compares a count or a field.
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_val

   // Pulses one command for one cycle: 0 start, 1 stop, 2 insert, 3 clear, 4 reset all.
   task automatic cmd(input int k);
      @(negedge sys_clk_i);
      start_i = (k == 0);
      stop_i = (k == 1);
      insert_err_i = (k == 2);
      clear_i = (k == 3);
      reset_all_i = (k == 4);
      @(negedge sys_clk_i);
      {start_i, stop_i, insert_err_i, clear_i, reset_all_i} = 5'h00;
   endtask : cmd

   // Asks the far end to corrupt the next n returned bits.
   task automatic flip(input logic [7:0] n);
      @(negedge sys_clk_i);
      flip_n = n;
      flip_ld = 1'b1;
      @(negedge sys_clk_i);
      flip_ld = 1'b0;
   endtask : flip

   // Counts sent bits that differ from the reference; pattern code 4 means host data.
   task automatic run_stream(input int pat, input logic inv, input int nbits, output int diffs);
      logic [22:0] r;
      logic fb;
      logic ex;
      int n;
      r = `BPGC_PRBS_SEED;
      diffs = 0;
      n = 0;
      for (int c = 0; c < nbits * 4 && n < nbits; c++)
      begin
         @(negedge sys_clk_i);
         if (tx_valid_o === 1'b1)
         begin
            fb = (pat == 3) ? (r[22] ^ r[17]) : (r[14] ^ r[13]);
            ex = (pat == 0) ? 1'b0 : (pat == 1) ? 1'b1 : (pat == 4) ? host_data_i : fb;
            if (tx_data_o !== (ex ^ inv))
               diffs++;
            r = {r[21:0], fb};
            n++;
         end
      end
      if (n < nbits)
         diffs = 99;
   endtask : run_stream

   // Waits a bounded time for the per-second count to show v, then compares.
   task automatic wait_sec(input logic [31:0] v);
      for (int c = 0; c < 300 && err_sec_o !== v; c++)
         @(negedge sys_clk_i);
      cmp_val(err_sec_o, v);
   endtask : wait_sec

   // Main sequence of tests.
   initial
   begin
      repeat (20) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      @(negedge sys_clk_i);
      cmp_bit(active_o | sync_o | tx_valid_o, 1'b0);
      cmp_val(err_total_o | err_sec_o, 32'h0);
      tx_on = 1'b1;
      run_stream(4, 1'b0, 16, d);
      cmp_val(32'(d), 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         tx_on = 1'b0;
         cmd(3);
         port_sel_i = i[2:0];
         dir_sel_i = i[1];
         pattern_i = bpgc_pkg::bpgc_pat_e'(i[1:0]);
         invert_i = i[2];
         cmd(0);
         cmp_bit(active_o, 1'b1);
         cmp_val(32'(port_o), 32'(i[2:0]));
         cmp_bit(dir_o, i[1]);
         port_sel_i = ~i[2:0];
         dir_sel_i = ~i[1];
         cmd(0);
         cmp_val(32'(port_o), 32'(i[2:0]));
         cmd(2);
         tx_on = 1'b1;
         run_stream(i % 4, i[2], 100, d);
         cmp_val(32'(d), 32'h1);
         cmp_bit(sync_o, 1'b1);
         cmp_val(err_total_o, 32'h0);
         flip(8'h02);
         repeat (40) @(negedge sys_clk_i);
         cmp_val(err_total_o, 32'h2);
         cmd(1);
         cmp_bit(active_o, 1'b0);
      end
      cmd(3);
      pattern_i = bpgc_pkg::PAT_PRBS23;
      invert_i = 1'b0;
      cmd(0);
      repeat (160) @(negedge sys_clk_i);
      cmp_bit(sync_o, 1'b1);
      flip(8'h01);
      wait_sec(32'h1);
      flip(8'h03);
      wait_sec(32'h3);
      wait_sec(32'h0);
      cmp_val(err_total_o, 32'h4);
      cmd(3);
      cmp_val(err_total_o | err_sec_o, 32'h0);
      cmp_bit(active_o, 1'b1);
      flip(8'h28);
      repeat (90) @(negedge sys_clk_i);
      cmp_bit(sync_o, 1'b0);
      cmd(4);
      cmp_bit(active_o, 1'b0);
      cmp_val(err_total_o | err_sec_o, 32'h0);
      give_verdict();
   end

   // Cuts a hang short well beyond the expected run of about 2600 cycles.
   initial
   begin
      #(20000 * 50);
      err_total++;
      give_verdict();
   end
endmodule : tb

`default_nettype wire
